/* src/radio_power_mode_map.vh */
// Purpose: constants for the power mode sequencer
// Assumes: 40 MHz clock
// Notes:   states are one-hot
`ifndef RADIO_POWER_MODE_MAP_VH
`define RADIO_POWER_MODE_MAP_VH
`define CLK_FREQ_HZ       40000000
`define ST_RESET          6'h01
`define ST_BOOT           6'h02
`define ST_ACTIVE         6'h04
`define ST_SLEEP          6'h08
`define ST_ALERT          6'h10
`define ST_RADIO          6'h20
`define ACT_STEPS         4'h4
`define ALERT_LEAD_NS     2000
`define ALERT_LEAD_CYC    ((`ALERT_LEAD_NS * 40 + 999) / 1000)
`define SLEEP_TIME_DEF    32'h00000400
`endif

/* src/wake_timer.v */
// Purpose: count down a sleep interval and pulse on expiry
// Assumes: synchronous active-high reset
// Notes:   load restarts the count
module wake_timer #(
  parameter W = 32
) (
  // clock and reset
  input  wire         clock,
  input  wire         sys_rst,
  // control
  input  wire         load,
  input  wire [W-1:0] load_val,
  input  wire         run,
  // status
  output reg          expired
);
  reg [W-1:0] cnt_q;

  // down counter, one expiry pulse
  always @(posedge clock) begin
    if (sys_rst) begin
      cnt_q   <= {W{1'b0}};
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (load) begin
        cnt_q <= load_val;
      end else if (run && cnt_q != {W{1'b0}}) begin
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        if (cnt_q == {{(W-1){1'b0}}, 1'b1})
          expired <= 1'b1;
      end
    end
  end
endmodule

/* src/radio_power_mode_sequencer.v */
// Purpose: sequence reset, sleep, active and radio modes
// Assumes: all inputs synchronous to clock; sys_rst is the reset pin
// Notes:   boot choice is latched on the first edge after reset release
`include "radio_power_mode_map.vh"

module radio_power_mode_sequencer #(
  parameter TW        = 32,
  parameter LEAD_CYC  = `ALERT_LEAD_CYC,
  parameter SLEEP_DEF = `SLEEP_TIME_DEF
) (
  // clock and reset
  clock,
  sys_rst,
  // software requests
  sleep_req,
  sleep_time,
  use_ring_osc,
  alert_enable,
  // radio scheduler
  radio_sched,
  radio_is_tx,
  radio_done,
  // boot strap pin
  boot_strap_pin,
  // power and clock controls
  regulators_on,
  hs_osc_on,
  ls_xtal_on,
  ls_ring_on,
  rf_if_on,
  core_run,
  retention_on,
  tx_on,
  rx_on,
  // mode and boot status
  mode_active,
  mode_sleep,
  boot_rom,
  boot_flash,
  boot_start,
  // event alert and shared gpio
  txrx_alert_out,
  shared_gpio_out,
  shared_gpio_oe_n,
  shared_gpio_pulldown
);
  input              clock;
  input              sys_rst;
  input              sleep_req;
  input  [TW-1:0]    sleep_time;
  input              use_ring_osc;
  input              alert_enable;
  input              radio_sched;
  input              radio_is_tx;
  input              radio_done;
  input              boot_strap_pin;
  output reg         regulators_on;
  output reg         hs_osc_on;
  output reg         ls_xtal_on;
  output reg         ls_ring_on;
  output reg         rf_if_on;
  output reg         core_run;
  output reg         retention_on;
  output reg         tx_on;
  output reg         rx_on;
  output reg         mode_active;
  output reg         mode_sleep;
  output reg         boot_rom;
  output reg         boot_flash;
  output reg         boot_start;
  output reg         txrx_alert_out;
  output wire        shared_gpio_out;
  output wire        shared_gpio_oe_n;
  output wire        shared_gpio_pulldown;

  localparam [5:0] S_RESET  = `ST_RESET;
  localparam [5:0] S_BOOT   = `ST_BOOT;
  localparam [5:0] S_ACTIVE = `ST_ACTIVE;
  localparam [5:0] S_SLEEP  = `ST_SLEEP;
  localparam [5:0] S_ALERT  = `ST_ALERT;
  localparam [5:0] S_RADIO  = `ST_RADIO;
  localparam [3:0] STEPS    = `ACT_STEPS;
  localparam [15:0] LEAD    = LEAD_CYC[15:0];

  reg  [5:0]  state_q;
  reg  [5:0]  state_d;
  reg  [3:0]  step_q;
  reg  [15:0] lead_q;
  reg         strap_done_q;
  reg         is_tx_q;
  reg         ring_q;
  wire        wake;
  wire        tmr_load;
  wire        ring_d;

  // load the wake interval on entry to sleep
  assign tmr_load = (state_q == S_ACTIVE) && sleep_req && !radio_sched;

  // oscillator choice as it stands once sleep is entered
  assign ring_d = tmr_load ? use_ring_osc : ring_q;

  wake_timer #(.W(TW)) u_wake (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .load     (tmr_load),
    .load_val ((sleep_time == {TW{1'b0}}) ? SLEEP_DEF[TW-1:0] : sleep_time),
    .run      (state_q == S_SLEEP),
    .expired  (wake)
  );

  // next mode
  always @* begin
    state_d = state_q;
    case (state_q)
      S_RESET:  state_d = S_BOOT;
      S_BOOT:   if (step_q == STEPS) state_d = S_ACTIVE;
      S_ACTIVE: begin
        if (radio_sched)
          state_d = alert_enable ? S_ALERT : S_RADIO;
        else if (sleep_req)
          state_d = S_SLEEP;
      end
      S_SLEEP:  if (wake) state_d = S_ACTIVE;
      S_ALERT:  if (lead_q == 16'h0000) state_d = S_RADIO;
      S_RADIO:  if (radio_done) state_d = S_ACTIVE;
      default:  state_d = S_RESET;
    endcase
  end

  // mode register and step counters
  always @(posedge clock) begin
    if (sys_rst) begin
      state_q <= S_RESET;
      step_q  <= 4'h0;
      lead_q  <= 16'h0000;
      is_tx_q <= 1'b0;
      ring_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      step_q  <= (state_q == S_BOOT) ? step_q + 4'h1 : 4'h0;
      if (state_q == S_ACTIVE && radio_sched) begin
        is_tx_q <= radio_is_tx;
        lead_q  <= (LEAD > 16'h0000) ? LEAD - 16'h0001 : 16'h0000;
      end else if (lead_q != 16'h0000) begin
        lead_q <= lead_q - 16'h0001;
      end
      if (tmr_load)
        ring_q <= use_ring_osc;
    end
  end

  // boot strap caught once on the first edge after release
  always @(posedge clock) begin
    if (sys_rst) begin
      strap_done_q <= 1'b0;
      boot_rom     <= 1'b0;
      boot_flash   <= 1'b0;
      boot_start   <= 1'b0;
    end else begin
      boot_start <= 1'b0;
      if (!strap_done_q) begin
        strap_done_q <= 1'b1;
        boot_rom     <= boot_strap_pin;
        boot_flash   <= !boot_strap_pin;
      end
      if (state_q == S_BOOT && step_q == STEPS)
        boot_start <= 1'b1;
    end
  end

  // power, clock and radio controls per mode
  always @(posedge clock) begin
    if (sys_rst) begin
      regulators_on  <= 1'b0;
      hs_osc_on      <= 1'b0;
      ls_xtal_on     <= 1'b0;
      ls_ring_on     <= 1'b0;
      rf_if_on       <= 1'b0;
      core_run       <= 1'b0;
      retention_on   <= 1'b0;
      tx_on          <= 1'b0;
      rx_on          <= 1'b0;
      mode_active    <= 1'b0;
      mode_sleep     <= 1'b0;
      txrx_alert_out <= 1'b0;
    end else begin
      regulators_on  <= (state_d != S_RESET) && (state_d != S_SLEEP);
      hs_osc_on      <= (state_d == S_ACTIVE) || (state_d == S_ALERT) ||
                        (state_d == S_RADIO);
      rf_if_on       <= (state_d == S_ACTIVE) || (state_d == S_ALERT) ||
                        (state_d == S_RADIO);
      core_run       <= (state_d == S_ACTIVE) || (state_d == S_ALERT) ||
                        (state_d == S_RADIO);
      ls_xtal_on     <= (state_d != S_RESET) && (state_d != S_BOOT) &&
                        !((state_d == S_SLEEP) && ring_d);
      ls_ring_on     <= (state_d == S_SLEEP) && ring_d;
      retention_on   <= (state_d != S_RESET);
      tx_on          <= (state_d == S_RADIO) && is_tx_q;
      rx_on          <= (state_d == S_RADIO) && !is_tx_q;
      mode_active    <= (state_d == S_ACTIVE);
      mode_sleep     <= (state_d == S_SLEEP);
      txrx_alert_out <= alert_enable &&
                        ((state_d == S_ALERT) || (state_d == S_RADIO));
    end
  end

  // shared gpio kept as released input with pull-down
  assign shared_gpio_out      = 1'b0;
  assign shared_gpio_oe_n     = 1'b1;
  assign shared_gpio_pulldown = 1'b1;
endmodule

/* verification/seq_chk.sv */
// Purpose: port assertions for the mode sequencer
// Assumes: one clock domain, sys_rst synchronous active high
// Notes:   bound to the design below
module seq_chk (
  // clock and requests
  input wire logic clock, sys_rst, sleep_req, radio_done, alert_enable,
  // power controls and modes
  input wire logic regulators_on, hs_osc_on, ls_xtal_on, ls_ring_on,
  input wire logic rf_if_on, core_run, retention_on, tx_on, rx_on,
  input wire logic mode_active, mode_sleep, txrx_alert_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // reset must also be watched while held, so no disable here
  property p_rst; disable iff (1'b0)
    sys_rst |=> !(regulators_on | hs_osc_on | rf_if_on); endproperty
  property p_act; $fell(sys_rst) |-> ##[1:8] mode_active; endproperty
  property p_slp; mode_sleep |-> retention_on && !hs_osc_on && !rf_if_on
    && (ls_xtal_on ^ ls_ring_on); endproperty
  property p_pwr; mode_active |-> hs_osc_on && rf_if_on && core_run;
  endproperty
  property p_one; (tx_on | rx_on) |-> !(tx_on && rx_on) && rf_if_on;
  endproperty
  property p_lead; alert_enable && $rose(tx_on | rx_on)
    |-> $past(txrx_alert_out); endproperty
  property p_fall; radio_done && (tx_on | rx_on)
    |=> !(txrx_alert_out | tx_on | rx_on); endproperty
  property p_req; $rose(mode_sleep) |-> $past(sleep_req); endproperty
  // one assertion per mode relation
  a_rst: assert property (p_rst) else $error("reset outputs");
  a_act: assert property (p_act) else $error("no active");
  a_slp: assert property (p_slp) else $error("sleep power");
  a_pwr: assert property (p_pwr) else $error("active power");
  a_one: assert property (p_one) else $error("radio mode");
  a_lead: assert property (p_lead) else $error("no lead");
  a_fall: assert property (p_fall) else $error("no fall");
  a_req: assert property (p_req) else $error("stray sleep");
  // main scenarios reached
  c_slp: cover property ($rose(mode_sleep));
  c_tx: cover property ($rose(tx_on));
  c_rx: cover property ($rose(rx_on));
endmodule

bind radio_power_mode_sequencer seq_chk u_chk (.clock, .sys_rst,
  .sleep_req, .radio_done, .alert_enable, .regulators_on, .hs_osc_on,
  .ls_xtal_on, .ls_ring_on, .rf_if_on, .core_run, .retention_on, .tx_on,
  .rx_on, .mode_active, .mode_sleep, .txrx_alert_out);

/* verification/ant_strap_model.sv */
// Purpose: antenna switch and boot strap source
// Assumes: switch is set by the alert line
// Notes:   fault marks rf running with the switch unset
module ant_strap_model (
  // clock and strap choice
  input  wire logic clock,
  input  wire logic want_rom,
  // radio side
  input  wire logic alert,
  input  wire logic rf_busy,
  // strap and status
  output wire logic strap,
  output logic      fault
);
  timeunit 1ns;
  timeprecision 100ps;
  // strap stays low unless the loader is wanted
  assign strap = want_rom;
  // rf must never run before the switch was set
  always @(posedge clock) fault <= rf_busy & ~alert;
endmodule

/* verification/testbench.sv */
// Purpose: self-checking bench for the mode sequencer
// Assumes: 40 MHz clock, alert lead cut to 3 cycles
// Notes:   strap and antenna switch come from the partner model
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam LEAD = 3;
  logic clock, sys_rst, sleep_req, use_ring, sched, is_tx, done, want_rom;
  logic alert_en;
  logic [31:0] stime;
  wire strap, fault, ring_on, tx_on, rx_on, act, slp, alert, b_rom, b_fl;
  wire b_st;
  wire regs, hs_osc, xtal_on, rf_on, core_on, ret_on;
  wire gp_out, gp_oe_n, gp_pd;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  radio_power_mode_sequencer #(.LEAD_CYC(LEAD)) u_dut (
    .clock(clock), .sys_rst(sys_rst), .sleep_req(sleep_req),
    .sleep_time(stime), .use_ring_osc(use_ring), .alert_enable(alert_en),
    .radio_sched(sched), .radio_is_tx(is_tx), .radio_done(done),
    .boot_strap_pin(strap), .regulators_on(regs), .hs_osc_on(hs_osc),
    .ls_xtal_on(xtal_on), .ls_ring_on(ring_on), .rf_if_on(rf_on),
    .core_run(core_on), .retention_on(ret_on), .tx_on(tx_on),
    .rx_on(rx_on), .mode_active(act), .mode_sleep(slp),
    .boot_rom(b_rom), .boot_flash(b_fl), .boot_start(b_st),
    .txrx_alert_out(alert), .shared_gpio_out(gp_out),
    .shared_gpio_oe_n(gp_oe_n), .shared_gpio_pulldown(gp_pd));
  ant_strap_model u_ant (.clock(clock), .want_rom(want_rom),
    .alert(alert), .rf_busy(tx_on | rx_on), .strap(strap), .fault(fault));
  // clock and hang guard
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares = miscompares + 1;
      stop_test();
    end
  end
  task automatic stop_test;
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // reset with a strap level, then wait for active
  task automatic t_boot(input logic rom);
    int n;
    logic seen;
    @(posedge clock) sys_rst <= 1'b1;
    want_rom <= rom;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    #1 chk({regs, hs_osc, xtal_on, rf_on, tx_on, alert}, 6'h00);
    seen = 1'b0;
    for (n = 0; n < 20 && act !== 1'b1; n++) begin
      @(posedge clock);
      #1 seen = seen | b_st;
    end
    chk(act, 1);
    chk(seen, 1);
    chk({b_rom, b_fl}, {rom, !rom});
    chk({regs, hs_osc, xtal_on, ring_on, rf_on, core_on, ret_on}, 7'h77);
    chk({gp_out, gp_oe_n, gp_pd}, 3'h3);
  endtask
  // software sleep, timed wake
  task automatic t_sleep(input logic [31:0] n, input logic r, input int e);
    int c;
    @(posedge clock) sleep_req <= 1'b1;
    stime <= n;
    use_ring <= r;
    @(posedge clock) sleep_req <= 1'b0;
    #1 chk({slp, ring_on}, {1'b1, r});
    chk({regs, hs_osc, rf_on, core_on, ret_on, xtal_on}, {5'h01, !r});
    for (c = 0; c < 2000 && act !== 1'b1; c++) begin
      @(posedge clock);
      #1;
    end
    chk(c, e + 1);
    chk({regs, hs_osc, xtal_on, ring_on, rf_on, core_on, ret_on}, 7'h77);
    repeat (8) @(posedge clock);
    #1 chk(slp, 0);
  endtask
  // scheduled radio event with alert lead
  task automatic t_radio(input logic tx);
    int c;
    @(posedge clock) sched <= 1'b1;
    is_tx <= tx;
    @(posedge clock) sched <= 1'b0;
    #1 chk({alert, tx_on, rx_on}, 3'h4);
    for (c = 0; c < 20 && (tx_on | rx_on) !== 1'b1; c++) begin
      @(posedge clock);
      #1;
    end
    chk(c, LEAD);
    chk({tx_on, rx_on}, {tx, !tx});
    chk({rf_on, hs_osc, core_on}, 3'h7);
    @(posedge clock) done <= 1'b1;
    @(posedge clock) done <= 1'b0;
    #1 chk({alert, tx_on, rx_on, fault}, 4'h0);
    chk(act, 1);
  endtask
  // radio event with the alert function switched off
  task automatic t_quiet(input logic tx);
    @(posedge clock) sched <= 1'b1;
    is_tx <= tx;
    alert_en <= 1'b0;
    @(posedge clock) sched <= 1'b0;
    #1 chk({alert, tx_on, rx_on}, {1'b0, tx, !tx});
    @(posedge clock) done <= 1'b1;
    @(posedge clock) done <= 1'b0;
    alert_en <= 1'b1;
    #1 chk({alert, tx_on, rx_on}, 3'h0);
    chk(act, 1);
  endtask
  // main sequence
  initial begin
    sys_rst = 1'b1;
    {sleep_req, use_ring, sched, is_tx, done, want_rom} = 6'h00;
    alert_en = 1'b1;
    stime = 32'h00000005;
    t_boot(1'b1);
    t_boot(1'b0);
    t_sleep(32'h00000005, 1'b0, 5);
    t_sleep(32'h00000001, 1'b1, 1);
    t_sleep(32'h00000000, 1'b0, 1024);
    t_radio(1'b1);
    t_radio(1'b0);
    t_quiet(1'b0);
    stop_test();
  end
endmodule
